//--- leak_resilient_secure_messaging_tb_top.sv
`timescale 1ns/100ps
module leak_resilient_secure_messaging_tb_top;
	logic clk = 1'b0;
	logic srst, cmd_valid, cmd_ready, sv_valid, pt_valid, pt_ready, blk_ready;
	logic mac_full_valid, mac_trunc_valid, hold;
	lrsm_pkg::lrsm_cmd_t cmd, c0;
	lrsm_pkg::lrsm_rsp_t rsp;
	lrsm_pkg::lrsm_macjob_t mac_job;
	lrsm_pkg::lrsm_byte_t pt;
	lrsm_pkg::lrsm_blk_t blk;
	lrsm_pkg::lrsm_auth_t auth_state;
	lrsm_pkg::lrsm_blk_t blk_q[$];
	logic [255:0] sv;
	logic [127:0] rnd_challenge, mac_full;
	logic [63:0] mac_trunc, et;
	logic [47:0] tcap;
	logic [31:0] rnd_tag, transaction_tag, cipher_block_counter, ec, tt;
	logic [15:0] command_sequence_counter, sq;
	int n_mismatch = 0;
	int check_count = 0;
	int i, k;

	always #4 clk = ~clk;

	lrsm_core DUT (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.rnd_challenge(rnd_challenge), .rnd_tag(rnd_tag), .tag_capability_bytes(tcap), .rsp(rsp),
		.mac_job(mac_job), .sv_valid(sv_valid), .sv(sv), .pt_valid(pt_valid), .pt_ready(pt_ready), .pt(pt),
		.blk(blk), .blk_ready(blk_ready), .mac_full_valid(mac_full_valid), .mac_full(mac_full),
		.mac_trunc_valid(mac_trunc_valid), .mac_trunc(mac_trunc), .auth_state(auth_state),
		.command_sequence_counter(command_sequence_counter), .transaction_tag(transaction_tag),
		.cipher_block_counter(cipher_block_counter));

	lrsm_reader_model RDR (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp(rsp),
		.mac_job(mac_job), .sv_valid(sv_valid), .sv(sv));

	// engine stand-in, stalls at random
	always @(negedge clk) blk_ready <= hold ? 1'b0 : 1'($urandom % 2);
	always @(posedge clk) if (blk.valid === 1'b1 && blk_ready === 1'b1) blk_q.push_back(blk);

	task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cmp_ans(input lrsm_pkg::lrsm_status_t st);
		cmp({RDR.got, RDR.got_rsp.status}, {1'b1, st});
	endtask

	task give_verdict;
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wait_blocks(input int n);
		int j;
		for (j = 0; j < 3000 && blk_q.size() < n; j++) @(posedge clk);
		if (j == 3000) begin
			cmp(256'h0, 256'h1);
			give_verdict();
		end
	endtask

	function automatic lrsm_pkg::lrsm_cmd_t mk(input lrsm_pkg::lrsm_kind_t kd, input logic ke, kg, mo, po);
		lrsm_pkg::lrsm_cmd_t c;
		c = '0;
		c.kind = kd;
		c.key_exists = ke;
		c.key_genuine = kg;
		c.mac_ok = mo;
		c.pad_ok = po;
		c.cap_len = 8'h06;
		c.data_len = 8'h07;
		c.cap_bytes = 48'({$urandom, $urandom});
		c.cap_bytes[41] = 1'b1;
		c.rdr_challenge = {$urandom, $urandom, $urandom, $urandom};
		return c;
	endfunction

	task automatic first_auth(input logic [7:0] clen);
		lrsm_pkg::lrsm_cmd_t c;
		logic [47:0] echo;
		c = mk(lrsm_pkg::CK_FIRST_P1, 1'b1, 1'b0, 1'b1, 1'b1);
		c.cap_len = clen;
		c.data_len = clen + 8'h01;
		@(negedge clk);
		rnd_challenge <= {$urandom, $urandom, $urandom, $urandom};
		rnd_tag <= $urandom;
		tcap <= 48'({$urandom, $urandom});
		RDR.xfer(c);
		cmp_ans(lrsm_pkg::RS_OK);
		cmp({RDR.got_rsp.send_challenge, RDR.got_rsp.challenge}, {1'b1, rnd_challenge});
		cmp({auth_state, command_sequence_counter, cipher_block_counter, transaction_tag},
			{lrsm_pkg::AS_PEND, 16'h0000, 32'h00000000, rnd_tag});
		// short capability lists echo with zero fill
		echo = (clen >= 8'h06) ? c.cap_bytes : (c.cap_bytes & ~(48'hFFFFFFFFFFFF >> (8 * clen)));
		c = mk(lrsm_pkg::CK_FIRST_P2, 1'b1, 1'b0, 1'b1, 1'b1);
		blk_q.delete();
		RDR.xfer(c);
		cmp({RDR.got, RDR.got_rsp.status, RDR.got_rsp.append_mac}, {1'b1, lrsm_pkg::RS_OK, 1'b1});
		cmp({RDR.got_job.valid, RDR.got_job.param, RDR.got_job.iv, RDR.got_job.truncate},
			{1'b1, 3'h4, 128'h0, 1'b0});
		cmp({RDR.got_sv_valid, RDR.got_sv[255:224], RDR.got_sv[15:0]}, {1'b1, 32'h00010080, 16'h9669});
		wait_blocks(1);
		cmp({blk_q[0].auth, blk_q[0].ctr, blk_q[0].data}, {1'b1, 32'h00000000, rnd_tag, tcap, echo});
		cmp({auth_state, cipher_block_counter}, {lrsm_pkg::AS_AUTH, 32'h00000001});
	endtask

	task automatic stream(input int n);
		logic [7:0] q[$];
		logic [127:0] d;
		logic [7:0] b;
		logic full_seen;
		int j, m;
		full_seen = 1'b0;
		blk_q.delete();
		// blocks held back first so a stream over 40 bytes fills the buffer and is refused
		hold = 1'b1;
		for (j = 0; j < n; j++) begin
			@(negedge clk);
			b = 8'($urandom);
			q.push_back(b);
			pt_valid <= 1'b1;
			pt.data <= b;
			pt.last <= (j == n - 1);
			for (m = 0; m < 400; m++) begin
				@(posedge clk);
				if (pt_ready === 1'b1) break;
				full_seen = 1'b1;
				hold = 1'b0;
			end
			if (m == 400) begin
				cmp(256'h0, 256'h1);
				give_verdict();
			end
		end
		@(negedge clk);
		pt_valid <= 1'b0;
		hold = 1'b0;
		q.push_back(8'h80);
		while (q.size() % 16 != 0) q.push_back(8'h00);
		wait_blocks(q.size() / 16);
		for (j = 0; j < q.size() / 16; j++) begin
			for (m = 0; m < 16; m++) d = {d[119:0], q[16 * j + m]};
			cmp({blk_q[j].auth, blk_q[j].ctr, blk_q[j].data}, {1'b0, ec + 32'(j), d});
		end
		ec = ec + 32'(q.size() / 16);
		cmp(cipher_block_counter, ec);
		if (n > 40) cmp(full_seen, 1'b1);
	endtask

	initial begin
		srst = 1'b1;
		pt_valid = 1'b0;
		pt = '0;
		mac_full_valid = 1'b0;
		mac_full = '0;
		rnd_challenge = '0;
		rnd_tag = '0;
		tcap = '0;
		hold = 1'b0;
		blk_ready = 1'b0;
		void'($urandom(10));
		repeat (16) @(posedge clk);
		@(negedge clk);
		srst <= 1'b0;
		repeat (2) @(negedge clk);
		cmp({auth_state, command_sequence_counter, transaction_tag, cipher_block_counter, cmd_ready, pt_ready},
			{lrsm_pkg::AS_NONE, 16'h0000, 32'h0, 32'h0, 1'b1, 1'b1});
		first_auth(8'h0A);
		ec = 32'h00000001;
		stream(16);
		stream(48);
		stream(1 + $urandom % 40);
		sq = command_sequence_counter;
		RDR.xfer(mk(lrsm_pkg::CK_SECURED, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp({RDR.got_rsp.append_mac, command_sequence_counter}, {1'b1, sq + 16'h0001});
		RDR.xfer(mk(lrsm_pkg::CK_OTHER, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp(command_sequence_counter, sq + 16'h0002);
		// follow-on while authenticated keeps tag and sequence
		tt = transaction_tag;
		sq = command_sequence_counter;
		blk_q.delete();
		RDR.xfer(mk(lrsm_pkg::CK_NEXT_P1, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_OK);
		RDR.xfer(mk(lrsm_pkg::CK_NEXT_P2, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_OK);
		cmp({auth_state, cipher_block_counter, command_sequence_counter, transaction_tag, 32'(blk_q.size())},
			{lrsm_pkg::AS_AUTH, 32'h0, sq, tt, 32'h0});
		ec = 32'h00000000;
		stream(16);
		// integrity failures, one per kind
		for (k = 0; k < 2; k++) begin
			first_auth(8'h02);
			RDR.xfer(mk(lrsm_pkg::CK_SECURED, 1'b1, 1'b0, 1'(k), 1'(1 - k)));
			cmp({RDR.got_rsp.status, RDR.got_rsp.append_mac, auth_state},
				{lrsm_pkg::RS_INTEGRITY, 1'b0, lrsm_pkg::AS_NONE});
		end
		RDR.xfer(mk(lrsm_pkg::CK_NEXT_P1, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_REJECT);
		RDR.xfer(mk(lrsm_pkg::CK_NEXT_P1, 1'b1, 1'b1, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_OK);
		RDR.xfer(mk(lrsm_pkg::CK_NEXT_P2, 1'b1, 1'b1, 1'b1, 1'b1));
		cmp({RDR.got_rsp.status, auth_state}, {lrsm_pkg::RS_OK, lrsm_pkg::AS_NONE});
		// part one then a stray command aborts
		RDR.xfer(mk(lrsm_pkg::CK_FIRST_P1, 1'b1, 1'b0, 1'b1, 1'b1));
		RDR.xfer(mk(lrsm_pkg::CK_OTHER, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp(auth_state, lrsm_pkg::AS_NONE);
		RDR.xfer(mk(lrsm_pkg::CK_FIRST_P2, 1'b1, 1'b0, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_REJECT);
		RDR.xfer(mk(lrsm_pkg::CK_FIRST_P1, 1'b0, 1'b0, 1'b1, 1'b1));
		cmp_ans(lrsm_pkg::RS_REJECT);
		c0 = mk(lrsm_pkg::CK_FIRST_P1, 1'b1, 1'b0, 1'b1, 1'b1);
		c0.cap_bytes[41] = 1'b0;
		RDR.xfer(c0);
		cmp({RDR.got_rsp.status, auth_state}, {lrsm_pkg::RS_FOREIGN, lrsm_pkg::AS_NONE});
		// length field disagreeing with the capability count
		c0 = mk(lrsm_pkg::CK_FIRST_P1, 1'b1, 1'b0, 1'b1, 1'b1);
		c0.data_len = 8'h09;
		RDR.xfer(c0);
		cmp({RDR.got_rsp.status, auth_state}, {lrsm_pkg::RS_REJECT, lrsm_pkg::AS_NONE});
		// truncation keeps bytes 14, 12 .. 0
		for (k = 0; k < 4; k++) begin
			@(negedge clk);
			mac_full <= {$urandom, $urandom, $urandom, $urandom};
			mac_full_valid <= 1'b1;
			@(negedge clk);
			mac_full_valid <= 1'b0;
			for (i = 0; i < 8; i++) et = {et[55:0], mac_full[8 * (14 - 2 * i) +: 8]};
			if (mac_trunc_valid !== 1'b1) @(negedge clk);
			cmp({mac_trunc_valid, mac_trunc}, {1'b1, et});
		end
		cmp(256'(RDR.stuck), 256'h0);
		give_verdict();
	end
endmodule

//--- lrsm_core.sv
`timescale 1ns/100ps
// Contract
// RULE1: macs are cmac over the resilient primitive, parameter 4, zero iv.
// RULE2: truncated mac keeps even-numbered bytes, msb first, eight bytes.
// RULE3: 32-bit block counter, cleared when either resilient auth starts.
// RULE4: block counter steps once per 16-byte block, padding block included.
// RULE5: after first auth, messaging starts at counter 1.
// RULE6: after follow-on auth, messaging starts at counter 0.
// RULE7: counter kept through auth state, fed msb first to key stream.
// RULE8: pad with 80h then zeros to 16; aligned data gets whole pad block.
// RULE9: no padding inside the authentication exchanges.
// RULE10: bit 1 of first reader capability byte picks resilient variant.
// RULE11: after part one, any command but part two aborts authentication; commands of an unlisted kind (default branch) leave it pending.
// RULE12: longer reader messages accepted when capability length is consistent.
// RULE13: first auth rejected when targeted key does not exist.
// RULE14: part one returns tag challenge, clears counters, new transaction tag.
// RULE15: reader sends its challenge plus full mac over both challenges.
// RULE16: verify part two mac; encrypt tag, tag caps and echoed reader caps.
// RULE17: echoed reader caps cut or zero-padded to six bytes.
// RULE18: response mac covers tag challenge, reader challenge, encrypted data.
// RULE19: reader rejects device answers of unexpected length.
// RULE20: follow-on rejected without active auth unless genuineness key.
// RULE21: follow-on skips caps, keeps tag and sequence counter, clears counter.
// RULE22: follow-on keeps auth unless genuineness key; any failure drops it.
// RULE23: mac or padding failure aborts, drops auth, error without mac.
// RULE24: session vector ends with label bytes 96h 69h after other fields.
// RULE25: auth states none, pending and authenticated, one step per command.

module lrsm_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// depth must be a power of two: pointers wrap by overflow
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} lrsm_fifo_st_t;

	lrsm_fifo_st_t s_ff;
	lrsm_fifo_st_t nxt_s;
	logic full;
	logic empty;

	assign empty = (s_ff.wp == s_ff.rp);
	assign full = (s_ff.wp[AW] != s_ff.rp[AW]) && (s_ff.wp[AW-1:0] == s_ff.rp[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s_ff.mem[s_ff.rp[AW-1:0]];

	always_comb begin
		nxt_s = s_ff;
		if (in_valid && !full) begin
			nxt_s.mem[s_ff.wp[AW-1:0]] = in_data;
			nxt_s.wp = s_ff.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			nxt_s.rp = s_ff.rp + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule

module lrsm_core #(
	parameter int DEPTH = lrsm_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// decoded reader commands
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire lrsm_pkg::lrsm_cmd_t cmd,
	// random sources and tag capabilities
	input wire logic [127:0] rnd_challenge,
	input wire logic [31:0] rnd_tag,
	input wire logic [47:0] tag_capability_bytes,
	// answers
	output lrsm_pkg::lrsm_rsp_t rsp,
	output lrsm_pkg::lrsm_macjob_t mac_job,
	output logic sv_valid,
	output logic [255:0] sv,
	// plain data to encrypt
	input wire logic pt_valid,
	output logic pt_ready,
	input wire lrsm_pkg::lrsm_byte_t pt,
	// blocks to the cipher engine
	output lrsm_pkg::lrsm_blk_t blk,
	input wire logic blk_ready,
	// mac truncation
	input wire logic mac_full_valid,
	input wire logic [127:0] mac_full,
	output logic mac_trunc_valid,
	output logic [63:0] mac_trunc,
	// status
	output lrsm_pkg::lrsm_auth_t auth_state,
	output logic [15:0] command_sequence_counter,
	output logic [31:0] transaction_tag,
	output logic [31:0] cipher_block_counter
);
	typedef struct packed {
		lrsm_pkg::lrsm_auth_t st;
		logic first;
		logic gen;
		logic [31:0] ctr;
		logic [15:0] cseq;
		logic [31:0] ttag;
		logic [127:0] tch;
		logic [47:0] cap;
		lrsm_pkg::lrsm_blk_t blk;
		lrsm_pkg::lrsm_rsp_t rsp;
		lrsm_pkg::lrsm_macjob_t mj;
		logic svv;
		logic [255:0] sv;
		logic [127:0] blkbuf;
		logic [4:0] cnt;
		logic pad;
		logic mark;
		logic tv;
		logic [63:0] tmac;
	} lrsm_core_st_t;

	lrsm_core_st_t s_ff;
	lrsm_core_st_t nxt_s;
	logic cmd_acc;
	logic blk_free;
	logic blk_load;
	logic len_ok;
	logic fo_valid;
	logic fo_ready;
	lrsm_pkg::lrsm_byte_t fo_data;
	logic [47:0] cap_adj;
	logic [63:0] trunc_w;
	logic [127:0] ra;

	lrsm_fifo #(
		.W($bits(lrsm_pkg::lrsm_byte_t)),
		.D(DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(srst),
		.in_valid(pt_valid),
		.in_ready(pt_ready),
		.in_data(pt),
		.out_valid(fo_valid),
		.out_ready(fo_ready),
		.out_data(fo_data)
	);

	genvar gi;
	generate
		// RULE17: cut or zero-fill
		for (gi = 0; gi < lrsm_pkg::CAP_ECHO_BYTES; gi++) begin : g_cap
			assign cap_adj[47-8*gi -: 8] = (cmd.cap_len > 8'(gi)) ? cmd.cap_bytes[47-8*gi -: 8] : 8'h00;
		end
		// RULE2: keep even bytes
		for (gi = 0; gi < 8; gi++) begin : g_trunc
			assign trunc_w[8*gi +: 8] = mac_full[16*gi +: 8];
		end
	endgenerate

	assign ra = cmd.rdr_challenge;
	// RULE12: capability length consistent
	assign len_ok = (cmd.data_len == lrsm_pkg::CAP_HDR_LEN + cmd.cap_len);
	// commands wait while a block is offered; a load yields to an accepted command, so counter clears never race a load
	assign cmd_ready = !s_ff.blk.valid;
	assign cmd_acc = cmd_valid && cmd_ready;
	assign blk_free = !s_ff.blk.valid || blk_ready;
	// stall the source while out of auth state rather than dropping bytes
	assign fo_ready = (s_ff.st == lrsm_pkg::AS_AUTH) && !s_ff.pad && (s_ff.cnt != lrsm_pkg::BLK_FULL);
	assign blk_load = (s_ff.st == lrsm_pkg::AS_AUTH) && (s_ff.cnt == lrsm_pkg::BLK_FULL) && blk_free && !cmd_acc;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.rsp.valid = 1'b0;
		nxt_s.mj.valid = 1'b0;
		nxt_s.svv = 1'b0;
		if (s_ff.blk.valid && blk_ready) begin
			nxt_s.blk.valid = 1'b0;
		end
		nxt_s.tv = mac_full_valid;
		if (mac_full_valid) begin
			nxt_s.tmac = trunc_w;
		end

		// packer: bytes enter msb first, then padding
		if (s_ff.st == lrsm_pkg::AS_AUTH) begin
			if (fo_valid && fo_ready) begin
				nxt_s.blkbuf = {s_ff.blkbuf[119:0], fo_data.data};
				nxt_s.cnt = s_ff.cnt + 5'h01;
				nxt_s.pad = fo_data.last;
			end else if (s_ff.pad && s_ff.cnt != lrsm_pkg::BLK_FULL) begin
				// RULE8: 80h then zeros
				nxt_s.blkbuf = {s_ff.blkbuf[119:0], s_ff.mark ? lrsm_pkg::PAD_FILL : lrsm_pkg::PAD_MARK};
				nxt_s.cnt = s_ff.cnt + 5'h01;
				nxt_s.mark = 1'b1;
			end
			if (blk_load) begin
				// RULE4: one step per block
				nxt_s.blk = '{valid: 1'b1, data: s_ff.blkbuf, ctr: s_ff.ctr, auth: 1'b0};
				nxt_s.ctr = s_ff.ctr + lrsm_pkg::CTR_STEP;
				nxt_s.cnt = 5'h00;
				// RULE8: aligned data keeps pad for a full block
				if (s_ff.pad && s_ff.mark) begin
					nxt_s.pad = 1'b0;
					nxt_s.mark = 1'b0;
				end
			end
		end else begin
			nxt_s.cnt = 5'h00;
			nxt_s.pad = 1'b0;
			nxt_s.mark = 1'b0;
		end

		if (cmd_acc) begin
			nxt_s.rsp = '{valid: 1'b1, status: lrsm_pkg::RS_OK, send_challenge: 1'b0,
				challenge: s_ff.rsp.challenge, append_mac: 1'b0};
			// RULE25: one transition per command
			unique case (cmd.kind)
				lrsm_pkg::CK_FIRST_P1: begin
					// RULE10: variant select bit
					if (!cmd.cap_bytes[lrsm_pkg::CAP_SEL_POS]) begin
						nxt_s.rsp.status = lrsm_pkg::RS_FOREIGN;
						nxt_s.st = lrsm_pkg::AS_NONE;
					// RULE13: missing key rejected
					end else if (!cmd.key_exists || !len_ok) begin
						nxt_s.rsp.status = lrsm_pkg::RS_REJECT;
						nxt_s.st = lrsm_pkg::AS_NONE;
					end else begin
						// RULE14: challenge, clears, new tag
						nxt_s.ctr = lrsm_pkg::CTR_RST;
						nxt_s.cseq = lrsm_pkg::CSEQ_RST;
						nxt_s.ttag = rnd_tag;
						nxt_s.tch = rnd_challenge;
						nxt_s.cap = cap_adj;
						nxt_s.first = 1'b1;
						nxt_s.gen = cmd.key_genuine;
						nxt_s.st = lrsm_pkg::AS_PEND;
						nxt_s.rsp.send_challenge = 1'b1;
						nxt_s.rsp.challenge = rnd_challenge;
					end
				end
				lrsm_pkg::CK_NEXT_P1: begin
					// RULE20: needs active auth
					if (!cmd.key_exists || (s_ff.st != lrsm_pkg::AS_AUTH && !cmd.key_genuine)) begin
						nxt_s.rsp.status = lrsm_pkg::RS_REJECT;
						nxt_s.st = lrsm_pkg::AS_NONE;
					end else begin
						// RULE21: only counter cleared
						nxt_s.ctr = lrsm_pkg::CTR_RST;
						nxt_s.tch = rnd_challenge;
						nxt_s.first = 1'b0;
						nxt_s.gen = cmd.key_genuine;
						nxt_s.st = lrsm_pkg::AS_PEND;
						nxt_s.rsp.send_challenge = 1'b1;
						nxt_s.rsp.challenge = rnd_challenge;
					end
				end
				lrsm_pkg::CK_FIRST_P2, lrsm_pkg::CK_NEXT_P2: begin
					// RULE16: verify mac first
					if (s_ff.st != lrsm_pkg::AS_PEND || s_ff.first != (cmd.kind == lrsm_pkg::CK_FIRST_P2) || !cmd.mac_ok) begin
						nxt_s.rsp.status = lrsm_pkg::RS_REJECT;
						nxt_s.st = lrsm_pkg::AS_NONE;
					end else begin
						// RULE24: label at the end
						nxt_s.sv = {lrsm_pkg::SV_HEAD_CTR, lrsm_pkg::SV_HEAD_LEN, ra[127:112],
							ra[111:64] ^ s_ff.tch[127:80], s_ff.tch[79:0], ra[63:0], lrsm_pkg::SV_LABEL};
						nxt_s.svv = 1'b1;
						if (s_ff.first) begin
							// RULE9: single unpadded block
							nxt_s.blk = '{valid: 1'b1, data: {s_ff.ttag, tag_capability_bytes, s_ff.cap},
								ctr: s_ff.ctr, auth: 1'b1};
							// RULE5: block 0 consumed here
							nxt_s.ctr = s_ff.ctr + lrsm_pkg::CTR_STEP;
							// RULE18: mac over challenges and cipher text
							// RULE1: parameter 4, zero iv
							nxt_s.mj = '{valid: 1'b1, param: lrsm_pkg::MAC_LRP_PARAM, iv: lrsm_pkg::MAC_IV,
								truncate: 1'b0};
							nxt_s.rsp.append_mac = 1'b1;
							nxt_s.st = lrsm_pkg::AS_AUTH;
						end else begin
							// RULE22: genuineness key leaves no auth
							nxt_s.st = s_ff.gen ? lrsm_pkg::AS_NONE : lrsm_pkg::AS_AUTH;
						end
					end
				end
				lrsm_pkg::CK_SECURED: begin
					// RULE11: pending auth aborted
					if (s_ff.st == lrsm_pkg::AS_PEND) begin
						nxt_s.rsp.status = lrsm_pkg::RS_REJECT;
						nxt_s.st = lrsm_pkg::AS_NONE;
					// RULE23: drop state, no mac
					end else if (!cmd.mac_ok || !cmd.pad_ok) begin
						nxt_s.rsp.status = lrsm_pkg::RS_INTEGRITY;
						nxt_s.st = lrsm_pkg::AS_NONE;
					end else if (s_ff.st == lrsm_pkg::AS_AUTH) begin
						nxt_s.cseq = s_ff.cseq + lrsm_pkg::CSEQ_STEP;
						nxt_s.rsp.append_mac = 1'b1;
					end
				end
				lrsm_pkg::CK_OTHER: begin
					// RULE11: pending auth aborted
					if (s_ff.st == lrsm_pkg::AS_PEND) begin
						nxt_s.st = lrsm_pkg::AS_NONE;
					end else if (s_ff.st == lrsm_pkg::AS_AUTH) begin
						nxt_s.cseq = s_ff.cseq + lrsm_pkg::CSEQ_STEP;
					end
				end
				default: begin
					nxt_s.rsp.status = lrsm_pkg::RS_REJECT;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rsp = s_ff.rsp;
	assign mac_job = s_ff.mj;
	assign sv_valid = s_ff.svv;
	assign sv = s_ff.sv;
	// RULE7: counter rides msb first
	assign blk = s_ff.blk;
	assign mac_trunc_valid = s_ff.tv;
	assign mac_trunc = s_ff.tmac;
	assign auth_state = s_ff.st;
	assign command_sequence_counter = s_ff.cseq;
	assign transaction_tag = s_ff.ttag;
	assign cipher_block_counter = s_ff.ctr;

	default clocking dc @(posedge clk); endclocking
	default disable iff (srst);

	AST_P1_CLEARS_CTR: assert property ( // RULE3
		cmd_acc && cmd.kind inside {lrsm_pkg::CK_FIRST_P1, lrsm_pkg::CK_NEXT_P1} && nxt_s.st == lrsm_pkg::AS_PEND
		|=> s_ff.ctr == lrsm_pkg::CTR_RST && s_ff.rsp.send_challenge)
		else $error("counter not cleared at auth start");
	AST_CTR_PER_BLOCK: assert property ( // RULE4
		blk_load |=> s_ff.blk.valid && s_ff.blk.ctr == $past(s_ff.ctr) && s_ff.ctr == $past(s_ff.ctr) + 32'h1)
		else $error("block counter did not step by one");
	AST_AUTH_BLK_AT_ZERO: assert property ( // RULE5
		s_ff.blk.valid && s_ff.blk.auth |-> s_ff.blk.ctr == lrsm_pkg::CTR_RST && s_ff.ctr == lrsm_pkg::CTR_SM_FIRST)
		else $error("auth block not at counter zero");
	AST_FOLLOW_CTR_ZERO: assert property ( // RULE6
		cmd_acc && cmd.kind == lrsm_pkg::CK_NEXT_P2 && nxt_s.st == lrsm_pkg::AS_AUTH
		|=> s_ff.ctr == lrsm_pkg::CTR_RST && !s_ff.blk.valid)
		else $error("follow-on auth moved the counter");
	AST_PEND_ABORT: assert property ( // RULE11
		cmd_acc && s_ff.st == lrsm_pkg::AS_PEND && cmd.kind inside {lrsm_pkg::CK_SECURED, lrsm_pkg::CK_OTHER}
		|=> s_ff.st == lrsm_pkg::AS_NONE)
		else $error("pending auth survived a foreign command");
	AST_NO_KEY: assert property ( // RULE13
		cmd_acc && cmd.kind == lrsm_pkg::CK_FIRST_P1 && cmd.cap_bytes[lrsm_pkg::CAP_SEL_POS] && !cmd.key_exists
		|=> s_ff.rsp.valid && s_ff.rsp.status == lrsm_pkg::RS_REJECT && s_ff.st == lrsm_pkg::AS_NONE)
		else $error("missing key not rejected");
	AST_GENUINE_DROPS: assert property ( // RULE22
		cmd_acc && cmd.kind == lrsm_pkg::CK_NEXT_P2 && s_ff.st == lrsm_pkg::AS_PEND && s_ff.gen
		|=> s_ff.st == lrsm_pkg::AS_NONE)
		else $error("genuineness key left device authenticated");
	AST_ERR_NO_MAC: assert property ( // RULE23
		s_ff.rsp.valid && s_ff.rsp.status == lrsm_pkg::RS_INTEGRITY |-> !s_ff.rsp.append_mac && s_ff.st == lrsm_pkg::AS_NONE)
		else $error("integrity error kept state or mac");
	AST_TRUNC: assert property ( // RULE2
		mac_full_valid |=> mac_trunc_valid && mac_trunc[63:56] == $past(mac_full[119:112])
		&& mac_trunc[7:0] == $past(mac_full[7:0]))
		else $error("mac truncation wrong");
	AST_PAD_MARK: assert property ( // RULE8
		s_ff.st == lrsm_pkg::AS_AUTH && s_ff.pad && !s_ff.mark && s_ff.cnt != lrsm_pkg::BLK_FULL
		&& !(fo_valid && fo_ready) |=> s_ff.blkbuf[7:0] == lrsm_pkg::PAD_MARK)
		else $error("padding did not start with 80h");

	COV_FIRST_AUTH: cover property (s_ff.blk.valid && s_ff.blk.auth ##1 s_ff.st == lrsm_pkg::AS_AUTH);
	COV_FOLLOW_AUTH: cover property (cmd_acc && cmd.kind == lrsm_pkg::CK_NEXT_P2 && nxt_s.st == lrsm_pkg::AS_AUTH);
	COV_PAD_BLOCK: cover property (blk_load && s_ff.pad && s_ff.mark);
	COV_INTEGRITY: cover property (s_ff.rsp.valid && s_ff.rsp.status == lrsm_pkg::RS_INTEGRITY);
endmodule

//--- lrsm_pkg.sv
package lrsm_pkg;

	// block assembly
	localparam int BLK_BYTES = 16;
	localparam logic [4:0] BLK_FULL = 5'h10;
	localparam logic [7:0] PAD_MARK = 8'h80;
	localparam logic [7:0] PAD_FILL = 8'h00;
	localparam int FIFO_DEPTH = 8;

	// counter values
	localparam logic [31:0] CTR_RST = 32'h00000000;
	localparam logic [31:0] CTR_SM_FIRST = 32'h00000001;
	localparam logic [31:0] CTR_STEP = 32'h00000001;
	localparam logic [15:0] CSEQ_RST = 16'h0000;
	localparam logic [15:0] CSEQ_STEP = 16'h0001;

	// mac construction
	localparam logic [2:0] MAC_LRP_PARAM = 3'h4;
	localparam logic [127:0] MAC_IV = 128'h0;

	// session vector fields
	localparam logic [15:0] SV_HEAD_CTR = 16'h0001;
	localparam logic [15:0] SV_HEAD_LEN = 16'h0080;
	localparam logic [15:0] SV_LABEL = 16'h9669;

	// reader capability handling
	localparam int CAP_ECHO_BYTES = 6;
	localparam int CAP_SEL_POS = 41;
	localparam logic [7:0] CAP_HDR_LEN = 8'h01;

	typedef enum logic [2:0] {
		CK_FIRST_P1,
		CK_FIRST_P2,
		CK_NEXT_P1,
		CK_NEXT_P2,
		CK_SECURED,
		CK_OTHER
	} lrsm_kind_t;

	typedef enum logic [1:0] {AS_NONE, AS_PEND, AS_AUTH} lrsm_auth_t;

	typedef enum logic [1:0] {RS_OK, RS_REJECT, RS_INTEGRITY, RS_FOREIGN} lrsm_status_t;

	typedef struct packed {
		lrsm_kind_t kind;
		logic key_exists;
		logic key_genuine;
		logic [7:0] data_len;
		logic [7:0] cap_len;
		logic [47:0] cap_bytes;
		logic [127:0] rdr_challenge;
		logic mac_ok;
		logic pad_ok;
	} lrsm_cmd_t;

	typedef struct packed {
		logic valid;
		lrsm_status_t status;
		logic send_challenge;
		logic [127:0] challenge;
		logic append_mac;
	} lrsm_rsp_t;

	typedef struct packed {
		logic valid;
		logic [127:0] data;
		logic [31:0] ctr;
		logic auth;
	} lrsm_blk_t;

	typedef struct packed {
		logic valid;
		logic [2:0] param;
		logic [127:0] iv;
		logic truncate;
	} lrsm_macjob_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} lrsm_byte_t;

endpackage

//--- lrsm_reader_model.sv
`timescale 1ns/100ps
module lrsm_reader_model (
	// clock
	input wire logic clk,
	// command side
	output logic cmd_valid,
	input wire logic cmd_ready,
	output lrsm_pkg::lrsm_cmd_t cmd,
	// answer side
	input wire lrsm_pkg::lrsm_rsp_t rsp,
	input wire lrsm_pkg::lrsm_macjob_t mac_job,
	input wire logic sv_valid,
	input wire logic [255:0] sv
);
	lrsm_pkg::lrsm_rsp_t got_rsp;
	lrsm_pkg::lrsm_macjob_t got_job;
	logic got_sv_valid;
	logic [255:0] got_sv;
	logic got;
	// sticky: a command never taken within the bound
	logic stuck;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		stuck = 1'b0;
	end
	// prompt or slow: random idle gap before each command
	task automatic xfer(input lrsm_pkg::lrsm_cmd_t c);
		int i;
		got = 1'b0;
		repeat ($urandom % 3) @(negedge clk);
		@(negedge clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (cmd_ready === 1'b1) break;
		end
		if (i == 64) stuck = 1'b1;
		@(negedge clk);
		cmd_valid <= 1'b0;
		// released fields flip so stale values cannot pass
		cmd <= lrsm_pkg::lrsm_cmd_t'(~c);
		for (i = 0; i < 3 && !got; i++) begin
			if (rsp.valid === 1'b1) begin
				got = 1'b1;
				got_rsp = rsp;
				got_job = mac_job;
				got_sv_valid = sv_valid;
				got_sv = sv;
			end else @(negedge clk);
		end
	endtask
endmodule
